//--- aotm_top.sv
// tamper monitor: opening event, playback blocking, removal window, authorised clear
//
// How it works
// R01: a detected service opening raises the dedicated opening event output.
// R02: playback stops and stays forbidden while event or module removal persists.
// R03: a start request while a door or panel is open is refused.
// R04: every disassembly path that exposes signals raises the event and blocks playback.
// R05: one latched event may cover several modules replaced in one session.
// R06: each module removal is detected singly and blocks playback without an event.
// R07: too many removals inside a sliding eight-hour window raise the event.
// R08: limit is at most sixteen; event fires when removals reach limit minus one, or at the first removal for limit one.
// R09: clearing the event keeps the removal history; later removals retrigger.
// R10: the alarm clears only with the physical key or the valid code.
// R11: each event logs an open record at start and a close record at end.
// R12: the event stays latched until an authorised clear.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "aotm_map.svh"
module aotm_top
  import aotm_pkg::*;
#(
  parameter int          NDOOR       = 2,
  parameter int          NMOD        = 16,
  parameter int          DEPTH       = 16,
  parameter logic [31:0] TICK_CYCLES = `AOTM_TICK_CYCLES,
  parameter logic [31:0] WIN_SEC     = `AOTM_WIN_SEC,
  parameter logic [15:0] AUTH_CODE   = 16'h1234
)(
  input  wire logic                     clk_sys_i,         // system clock, 25 MHz
  input  wire logic                     rst_i,             // synchronous reset, active high
  input  wire logic [NDOOR-1:0]         door_open_i,       // security door or panel open
  input  wire logic [NMOD-1:0]          module_present_i,  // front module seated
  input  wire logic                     service_key_i,     // physical key turned
  input  wire logic                     play_req_i,        // request to start playback
  input  wire logic                     play_stop_i,       // request to stop playback
  input  wire logic [`AOTM_ADDR_W-1:0]  addr_i,            // register address
  input  wire logic [31:0]              wdata_i,           // register write data
  input  wire logic                     wr_i,              // write strobe
  input  wire logic                     rd_i,              // read strobe
  output logic [31:0]                   rdata_o,           // read data, cycle after rd_i
  output logic                          access_open_evt_o, // security access opening event
  output logic                          play_allow_o,      // playback permitted
  output logic                          play_active_o,     // playback running
  output logic                          enclosure_open_record_o,  // open record pulse
  output logic                          enclosure_close_record_o, // close record pulse
  output logic                          irq_o              // interrupt, level
);

  localparam int CW = $clog2(DEPTH + 1);

  function automatic logic [NMOD-1:0] lowest_bit(input logic [NMOD-1:0] v);
    lowest_bit = v & (~v + 1'b1);
  endfunction : lowest_bit

  function automatic logic [`AOTM_LIMIT_W-1:0] clamp_limit(input logic [31:0] v);
    if (v == 32'h0)
      clamp_limit = `AOTM_LIMIT_W'(1);
    else if (v > 32'(`AOTM_LIMIT_MAX))
      clamp_limit = `AOTM_LIMIT_MAX;
    else
      clamp_limit = v[`AOTM_LIMIT_W-1:0];
  endfunction : clamp_limit

  ////////////////////////////////////////////////////////////////////////////
  // time base: one tick a second, free-running seconds counter
  // ages are taken as differences, so a wrap of the seconds count is harmless

  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  aotm_time_t  now_sec;
  aotm_time_t  next_now_sec;

  always_comb
  begin
    if (tick_cnt >= TICK_CYCLES - 32'd1)
    begin
      next_tick_cnt = '0;
      next_now_sec  = now_sec + 32'd1;
    end
    else
    begin
      next_tick_cnt = tick_cnt + 32'd1;
      next_now_sec  = now_sec;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      tick_cnt <= '0;
      now_sec  <= '0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      now_sec  <= next_now_sec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // module removal detection and window counting

  logic [NMOD-1:0]  present_q;
  logic [NMOD-1:0]  pend;
  logic [NMOD-1:0]  next_pend;
  logic [NMOD-1:0]  removed;
  logic             push;
  logic             push_q;
  logic             mod_out;
  logic             door_any;
  logic [CW-1:0]    win_cnt;
  logic [`AOTM_LIMIT_W-1:0] removal_limit;
  logic             win_trig;

  always_comb
  begin
    removed   = present_q & ~module_present_i;                 // [R06]
    // several removals in one cycle are queued and recorded one per cycle
    push      = |pend;
    next_pend = (pend & ~lowest_bit(pend)) | removed;          // [R06]
    mod_out   = ~&module_present_i;
    door_any  = |door_open_i;
    // fire once the window count reaches limit minus one; limit one fires at the first removal
    win_trig  = push_q &&
                (32'(win_cnt) + 32'd1 >= 32'(removal_limit));   // [R07] [R08]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      present_q <= '1;
      pend      <= '0;
      push_q    <= 1'b0;
    end
    else
    begin
      present_q <= module_present_i;
      pend      <= next_pend;
      push_q    <= push;
    end
  end

  aotm_window #(
    .DEPTH   (DEPTH),
    .CW      (CW)
  ) u_window (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .push_i    (push),
    .now_i     (now_sec),
    .win_i     (WIN_SEC),
    .count_o   (win_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // opening event latch, authorised clear, playback control

  logic       auth_clr;
  logic       next_evt;
  aotm_play_t play_st;
  aotm_play_t next_play_st;
  logic       blocked;
  logic       refused;
  logic       next_allow;

  always_comb
  begin
    // a wrong code with the key off is ignored without any trace
    auth_clr = wr_i && (addr_i == `AOTM_OFF_CLEAR) &&
               (service_key_i || wdata_i[`AOTM_CODE_W-1:0] == AUTH_CODE);   // [R10]
    // set wins over clear; one latch covers a whole service session
    next_evt = (access_open_evt_o & ~auth_clr)                          // [R12] [R05] [R09]
               | door_any                                               // [R01] [R04]
               | win_trig;                                              // [R07]
    blocked  = access_open_evt_o | mod_out | door_any;                  // [R02] [R06]
    refused  = play_req_i & blocked;                                    // [R03]
    next_allow = ~blocked;                                              // [R02]
    case (play_st)
      AOTM_PL_IDLE:
        next_play_st = (play_req_i && !blocked) ? AOTM_PL_RUN : AOTM_PL_IDLE; // [R03]
      AOTM_PL_RUN:
        next_play_st = (blocked || play_stop_i) ? AOTM_PL_IDLE : AOTM_PL_RUN; // [R02] [R04]
      default:
        next_play_st = AOTM_PL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      access_open_evt_o <= 1'b0;
      play_st           <= AOTM_PL_IDLE;
      play_allow_o      <= 1'b0;
    end
    else
    begin
      access_open_evt_o <= next_evt;
      play_st           <= next_play_st;
      play_allow_o      <= next_allow;
    end
  end

  assign play_active_o = (play_st == AOTM_PL_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // open and close records

  logic [15:0] open_cnt;
  logic [15:0] close_cnt;
  aotm_time_t  last_ts;

  aotm_logger u_logger (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .event_i     (access_open_evt_o),        // [R11]
    .now_i       (now_sec),
    .open_o      (enclosure_open_record_o),
    .close_o     (enclosure_close_record_o),
    .open_cnt_o  (open_cnt),
    .close_cnt_o (close_cnt),
    .last_ts_o   (last_ts)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register port and interrupt

  logic [`AOTM_IRQ_W-1:0] irq_stat;
  logic [`AOTM_IRQ_W-1:0] next_irq_stat;
  logic [`AOTM_IRQ_W-1:0] irq_mask;
  logic [`AOTM_IRQ_W-1:0] next_irq_mask;
  logic [`AOTM_IRQ_W-1:0] irq_set;
  logic [`AOTM_LIMIT_W-1:0] next_limit;
  logic [31:0]            next_rdata;
  logic                   next_irq;

  always_comb
  begin
    irq_set = '0;
    irq_set[`AOTM_IRQ_OPEN]    = enclosure_open_record_o;
    irq_set[`AOTM_IRQ_CLOSE]   = enclosure_close_record_o;
    irq_set[`AOTM_IRQ_REMOVAL] = push;
    irq_set[`AOTM_IRQ_REFUSED] = refused;
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    next_limit    = removal_limit;
    if (wr_i)
    begin
      case (addr_i)
        `AOTM_OFF_CTRL:     next_limit    = clamp_limit(wdata_i);            // [R08]
        `AOTM_OFF_IRQ_STAT: next_irq_stat = irq_stat & ~wdata_i[`AOTM_IRQ_W-1:0];
        `AOTM_OFF_IRQ_MASK: next_irq_mask = wdata_i[`AOTM_IRQ_W-1:0];
        default:            next_limit    = removal_limit;
      endcase
    end
    next_irq_stat = next_irq_stat | irq_set;
    next_irq      = |(next_irq_stat & next_irq_mask);
    // read data is zero in any cycle not following a read strobe
    next_rdata    = '0;
    if (rd_i)
    begin
      case (addr_i)
        `AOTM_OFF_CTRL:     next_rdata = 32'(removal_limit);
        `AOTM_OFF_STATUS:
        begin
          next_rdata[`AOTM_ST_EVENT]  = access_open_evt_o;
          next_rdata[`AOTM_ST_PLAY]   = play_active_o;
          next_rdata[`AOTM_ST_MODOUT] = mod_out;
          next_rdata[`AOTM_ST_DOOR]   = door_any;
        end
        `AOTM_OFF_IRQ_STAT: next_rdata = 32'(irq_stat);
        `AOTM_OFF_IRQ_MASK: next_rdata = 32'(irq_mask);
        `AOTM_OFF_WCOUNT:   next_rdata = 32'(win_cnt);
        `AOTM_OFF_LOGCNT:   next_rdata = {close_cnt, open_cnt};
        `AOTM_OFF_LAST_TS:  next_rdata = last_ts;
        default:            next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      irq_stat      <= '0;
      irq_mask      <= `AOTM_MASK_RST;
      removal_limit <= `AOTM_LIMIT_RST;
      rdata_o       <= '0;
      irq_o         <= 1'b0;
    end
    else
    begin
      irq_stat      <= next_irq_stat;
      irq_mask      <= next_irq_mask;
      removal_limit <= next_limit;
      rdata_o       <= next_rdata;
      irq_o         <= next_irq;
    end
  end

endmodule : aotm_top

//--- aotm_map.svh
// register offsets, field positions, reset values and timing figures of the tamper monitor
`ifndef AOTM_MAP_SVH
`define AOTM_MAP_SVH

`define AOTM_ADDR_W       8
`define AOTM_OFF_CTRL     8'h00
`define AOTM_OFF_STATUS   8'h04
`define AOTM_OFF_IRQ_STAT 8'h08
`define AOTM_OFF_IRQ_MASK 8'h0c
`define AOTM_OFF_CLEAR    8'h10
`define AOTM_OFF_WCOUNT   8'h14
`define AOTM_OFF_LOGCNT   8'h18
`define AOTM_OFF_LAST_TS  8'h1c

`define AOTM_LIMIT_W      5
`define AOTM_LIMIT_RST    5'h10
`define AOTM_LIMIT_MAX    5'h10
`define AOTM_MASK_RST     4'h0
`define AOTM_CODE_W       16

`define AOTM_ST_EVENT     0
`define AOTM_ST_PLAY      1
`define AOTM_ST_MODOUT    2
`define AOTM_ST_DOOR      3

`define AOTM_IRQ_W        4
`define AOTM_IRQ_OPEN     0
`define AOTM_IRQ_CLOSE    1
`define AOTM_IRQ_REMOVAL  2
`define AOTM_IRQ_REFUSED  3

`define AOTM_CLK_HZ       32'd25000000
`define AOTM_TICK_SEC     32'd1
`define AOTM_TICK_CYCLES  (`AOTM_CLK_HZ * `AOTM_TICK_SEC)
`define AOTM_WIN_HOURS    32'd8
`define AOTM_SEC_PER_HOUR 32'd3600
`define AOTM_WIN_SEC      (`AOTM_WIN_HOURS * `AOTM_SEC_PER_HOUR)

`endif

//--- aotm_pkg.sv
// types shared by the tamper monitor modules
package aotm_pkg;

  typedef enum logic [0:0] {
    AOTM_PL_IDLE = 1'b0,
    AOTM_PL_RUN  = 1'b1
  } aotm_play_t;

  typedef logic [31:0] aotm_time_t;

endpackage : aotm_pkg

//--- aotm_window.sv
// sliding-window store of removal time stamps and count of those still inside the window
`timescale 1ns/1ps
module aotm_window
  import aotm_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
)(
  input  wire logic          clk_sys_i, // system clock
  input  wire logic          rst_i,     // synchronous reset, active high
  input  wire logic          push_i,    // one removal to record
  input  wire aotm_time_t    now_i,     // current time in seconds
  input  wire aotm_time_t    win_i,     // window length in seconds
  output logic [CW-1:0]      count_o    // removals inside the window
);

  localparam int PW = $clog2(DEPTH);

  aotm_time_t      ts      [DEPTH];
  aotm_time_t      next_ts [DEPTH];
  logic [DEPTH-1:0] vld;
  logic [DEPTH-1:0] next_vld;
  logic [PW-1:0]    wp;
  logic [PW-1:0]    next_wp;
  logic [CW-1:0]    next_count;

  always_comb
  begin
    next_ts    = ts;
    next_vld   = vld;
    next_wp    = wp;
    next_count = '0;
    // entries that aged out leave the history; clearing an alarm never touches it
    for (int i = 0; i < DEPTH; i++)
    begin
      if (vld[i] && (now_i - ts[i] >= win_i))
      begin
        next_vld[i] = 1'b0;
      end
    end
    if (push_i)
    begin
      next_ts[wp]  = now_i;
      next_vld[wp] = 1'b1;
      next_wp      = PW'(wp + 1'b1);
    end
    for (int i = 0; i < DEPTH; i++)
    begin
      next_count = CW'(next_count + CW'(next_vld[i]));
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      vld     <= '0;
      wp      <= '0;
      count_o <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        ts[i] <= '0;
      end
    end
    else
    begin
      ts      <= next_ts;
      vld     <= next_vld;
      wp      <= next_wp;
      count_o <= next_count;
    end
  end

endmodule : aotm_window

//--- aotm_logger.sv
// open and close record generator for the security access opening event
`timescale 1ns/1ps
module aotm_logger
  import aotm_pkg::*;
(
  input  wire logic       clk_sys_i, // system clock
  input  wire logic       rst_i,     // synchronous reset, active high
  input  wire logic       event_i,   // latched opening event
  input  wire aotm_time_t now_i,     // current time in seconds
  output logic            open_o,    // one-cycle open record
  output logic            close_o,   // one-cycle close record
  output logic [15:0]     open_cnt_o,  // open records so far
  output logic [15:0]     close_cnt_o, // close records so far
  output aotm_time_t      last_ts_o    // time of the latest record
);

  logic        evt_q;
  logic        next_open;
  logic        next_close;
  logic [15:0] next_open_cnt;
  logic [15:0] next_close_cnt;
  aotm_time_t  next_last_ts;

  always_comb
  begin
    next_open      = event_i & ~evt_q;
    next_close     = ~event_i & evt_q;
    next_open_cnt  = open_cnt_o + 16'(next_open);
    next_close_cnt = close_cnt_o + 16'(next_close);
    next_last_ts   = (next_open | next_close) ? now_i : last_ts_o;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      evt_q       <= 1'b0;
      open_o      <= 1'b0;
      close_o     <= 1'b0;
      open_cnt_o  <= '0;
      close_cnt_o <= '0;
      last_ts_o   <= '0;
    end
    else
    begin
      evt_q       <= event_i;
      open_o      <= next_open;
      close_o     <= next_close;
      open_cnt_o  <= next_open_cnt;
      close_cnt_o <= next_close_cnt;
      last_ts_o   <= next_last_ts;
    end
  end

endmodule : aotm_logger

//--- aotm_monitor.sv
// port checker of the tamper monitor and its bind
`timescale 1ns/1ps
`include "aotm_map.svh"
module aotm_monitor
  import aotm_pkg::*;
#(
  parameter int          NDOOR     = 2,
  parameter int          NMOD      = 16,
  parameter logic [15:0] AUTH_CODE = 16'h1234
)(
  input wire logic                    clk_sys_i,         // clock
  input wire logic                    rst_i,             // reset
  input wire logic [NDOOR-1:0]        door_open_i,       // doors
  input wire logic [NMOD-1:0]         module_present_i,  // modules
  input wire logic                    service_key_i,     // key
  input wire logic                    play_req_i,        // start request
  input wire logic [`AOTM_ADDR_W-1:0] addr_i,            // address
  input wire logic [31:0]             wdata_i,           // write data
  input wire logic                    wr_i,              // write strobe
  input wire logic                    access_open_evt_o, // event
  input wire logic                    play_allow_o,      // allow
  input wire logic                    play_active_o,     // playing
  input wire logic                    enclosure_open_record_o,  // open pulse
  input wire logic                    enclosure_close_record_o  // close pulse
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  wire logic clr = wr_i && addr_i == `AOTM_OFF_CLEAR;
  wire logic blk = access_open_evt_o || |door_open_i;
  //////////////////////////////////////////////////////////////////////////////
  chk_door_event: assert property (|door_open_i |=> access_open_evt_o)
    else $error("door open without event");
  chk_evt_block: assert property (access_open_evt_o |=> !play_allow_o)
    else $error("playback allowed during event");
  chk_module_block: assert property (!(&module_present_i) |=> !play_allow_o)
    else $error("playback allowed with module out");
  chk_door_refuse: assert property (|door_open_i && !play_active_o && play_req_i
    |=> !play_active_o) else $error("start accepted with door open");
  chk_play_stop: assert property (blk && play_active_o |=> !play_active_o)
    else $error("playback kept during event");
  chk_evt_latch: assert property (access_open_evt_o && !clr |=> access_open_evt_o)
    else $error("event dropped without clear");
  chk_clear_auth: assert property ($fell(access_open_evt_o) |->
    $past(clr && (wdata_i[15:0] == AUTH_CODE || service_key_i)))
    else $error("event cleared without key or code");
  chk_open_rec: assert property ($rose(access_open_evt_o) |=> enclosure_open_record_o)
    else $error("open record missing");
  chk_close_rec: assert property ($fell(access_open_evt_o) ##1 1'b1
    |-> enclosure_close_record_o) else $error("close record missing");
  cover property ($rose(access_open_evt_o));
  cover property (play_req_i ##1 play_active_o);
  cover property (enclosure_close_record_o);
endmodule : aotm_monitor

bind aotm_top aotm_monitor #(.NDOOR(NDOOR), .NMOD(NMOD), .AUTH_CODE(AUTH_CODE)) i_mon (
  .clk_sys_i, .rst_i, .door_open_i, .module_present_i, .service_key_i, .play_req_i,
  .addr_i, .wdata_i, .wr_i, .access_open_evt_o, .play_allow_o, .play_active_o,
  .enclosure_open_record_o, .enclosure_close_record_o);

//--- aotm_companion.sv
// companion block model: keeps the open and close record log
`timescale 1ns/1ps
module aotm_companion (
  input  wire logic       clk_sys_i,   // system clock
  input  wire logic       rst_i,       // reset
  input  wire logic       open_i,      // open record pulse
  input  wire logic       close_i,     // close record pulse
  output logic [7:0]      open_cnt_o,  // open records logged
  output logic [7:0]      close_cnt_o  // close records logged
);
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      open_cnt_o  <= 8'h00;
      close_cnt_o <= 8'h00;
    end
    else
    begin
      open_cnt_o  <= open_cnt_o + 8'(open_i);
      close_cnt_o <= close_cnt_o + 8'(close_i);
    end
  end
endmodule : aotm_companion

//--- tb.sv
// testbench of the tamper monitor
`timescale 1ns/1ps
`include "aotm_map.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  import aotm_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [1:0]  door      = 2'h0;
  logic [15:0] mods      = 16'hffff;
  logic        key       = 1'b0;
  logic        req       = 1'b0;
  logic        stp       = 1'b0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic [31:0] rdata;
  logic        evt;
  logic        allow;
  logic        act;
  logic        orec;
  logic        crec;
  logic        irq;
  logic [7:0]  ocnt;
  logic [7:0]  ccnt;
  int          error_cnt   = 0;
  int          checks_done = 0;
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  aotm_top #(.TICK_CYCLES(32'd10), .WIN_SEC(32'd100)) i_dut (
    .clk_sys_i, .rst_i, .door_open_i(door), .module_present_i(mods),
    .service_key_i(key), .play_req_i(req), .play_stop_i(stp), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .access_open_evt_o(evt),
    .play_allow_o(allow), .play_active_o(act), .enclosure_open_record_o(orec),
    .enclosure_close_record_o(crec), .irq_o(irq));
  aotm_companion i_comp (.clk_sys_i, .rst_i, .open_i(orec), .close_i(crec),
    .open_cnt_o(ocnt), .close_cnt_o(ccnt));
  //////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk_sys_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask : rd_reg
  task automatic pulse(input bit stop);
    @(posedge clk_sys_i);
    if (stop)
      stp <= 1'b1;
    else
      req <= 1'b1;
    @(posedge clk_sys_i);
    stp <= 1'b0;
    req <= 1'b0;
    #1;
  endtask : pulse
  // one module out for six cycles, then seated again
  task automatic remove(input int m);
    @(posedge clk_sys_i);
    mods[m] <= 1'b0;
    cyc(5);
    @(posedge clk_sys_i);
    mods[m] <= 1'b1;
    #1;
  endtask : remove
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    close_out();
  end
  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    cyc(1);
    rd_reg(`AOTM_OFF_CTRL, 32'h10, "limit");
    rd_reg(`AOTM_OFF_STATUS, 32'h0, "status");
    rd_reg(8'hf0, 32'h0, "unmapped");
    wr_reg(`AOTM_OFF_IRQ_MASK, 32'h1);
    pulse(0);
    `CHK("play", 1'b1, act)
    @(posedge clk_sys_i);
    door <= 2'h2;
    cyc(1);
    `CHK("evt", 1'b1, evt)
    `CHK("stop", 1'b0, act)
    pulse(0);
    `CHK("refuse", 1'b0, act)
    cyc(2);
    `CHK("open log", 8'h1, ocnt)
    `CHK("irq", 1'b1, irq)
    rd_reg(`AOTM_OFF_IRQ_STAT, 32'h9, "irq stat");
    @(posedge clk_sys_i);
    door <= 2'h0;
    cyc(3);
    `CHK("latched", 1'b1, evt)
    wr_reg(`AOTM_OFF_CLEAR, 32'h4321);
    cyc(1);
    `CHK("bad code", 1'b1, evt)
    wr_reg(`AOTM_OFF_CLEAR, 32'h1234);
    cyc(2);
    `CHK("cleared", 1'b0, evt)
    `CHK("close log", 8'h1, ccnt)
    wr_reg(`AOTM_OFF_IRQ_STAT, 32'hf);
    cyc(2);
    `CHK("irq clr", 1'b0, irq)
    pulse(0);
    `CHK("play again", 1'b1, act)
    @(posedge clk_sys_i);
    mods[5] <= 1'b0;
    cyc(2);
    `CHK("mod stop", 1'b0, act)
    `CHK("mod allow", 1'b0, allow)
    `CHK("no evt", 1'b0, evt)
    @(posedge clk_sys_i);
    mods[5] <= 1'b1;
    pulse(0);
    `CHK("replay", 1'b1, act)
    `CHK("allow back", 1'b1, allow)
    pulse(1);
    `CHK("stopped", 1'b0, act)
    // limit four fires at the third removal in the window
    wr_reg(`AOTM_OFF_CTRL, 32'h4);
    remove(0);
    `CHK("below", 1'b0, evt)
    remove(1);
    `CHK("limit evt", 1'b1, evt)
    rd_reg(`AOTM_OFF_WCOUNT, 32'h3, "count");
    @(posedge clk_sys_i);
    key <= 1'b1;
    wr_reg(`AOTM_OFF_CLEAR, 32'h0);
    key <= 1'b0;
    cyc(1);
    `CHK("key clr", 1'b0, evt)
    remove(2);
    `CHK("retrigger", 1'b1, evt)
    remove(3);
    cyc(3);
    `CHK("one event", 8'h3, ocnt)
    wr_reg(`AOTM_OFF_CLEAR, 32'h1234);
    cyc(1100);
    rd_reg(`AOTM_OFF_WCOUNT, 32'h0, "expired");
    remove(4);
    `CHK("window", 1'b0, evt)
    `CHK("close all", 8'h3, ccnt)
    rd_reg(`AOTM_OFF_LOGCNT, 32'h00030003, "log count");
    @(posedge clk_sys_i);
    mods[7] <= 1'b0;
    cyc(1);
    rd_reg(`AOTM_OFF_STATUS, 32'h4, "status mod");
    @(posedge clk_sys_i);
    mods[7] <= 1'b1;
    rd_reg(`AOTM_OFF_IRQ_STAT, 32'h7, "irq bits");
    wr_reg(`AOTM_OFF_CTRL, 32'h0);
    rd_reg(`AOTM_OFF_CTRL, 32'h1, "limit min");
    wr_reg(`AOTM_OFF_CTRL, 32'h40);
    rd_reg(`AOTM_OFF_CTRL, 32'h10, "limit cap");
    close_out();
  end
endmodule : tb
